/* frci_flash_model.sv */
// Behavioural serial flash: mode-0 slave with status and configuration.
// Assumes the issuer drives chip select, serial clock and the data line.
`timescale 1ns/10ps
`default_nettype none
module frci_flash_model #(
    parameter int POLLS = 2
) (
    input  wire logic cs_n_i,
    input  wire logic sclk_i,
    input  wire logic mosi_i,
    output logic      miso_o
);
    // ========================================================================
    // State
    logic [7:0]  op        = 8'h00;
    logic [7:0]  stat_wr   = 8'h00;
    logic [7:0]  cfg       = 8'h00;
    logic [7:0]  outb      = 8'h00;
    logic [23:0] sh        = 24'h000000;
    logic        wlatch    = 1'b0;
    logic        wbusy     = 1'b0;
    logic        miso_q    = 1'b0;
    int          nbit      = 0;
    int          polls     = 0;
    int          wena_miss = 0;
    logic [7:0]  ops[$];
    int          bits[$];

    assign miso_o = miso_q;

    // ========================================================================
    // Frame decode
    always @(negedge cs_n_i) begin
        nbit = 0;
    end
    always @(posedge sclk_i) begin
        if (!cs_n_i) begin
            sh = {sh[22:0], mosi_i};
            nbit++;
            if (nbit == 8) begin
                op = sh[7:0];
                outb = (op == frci_pkg::CMD_READ_CONFIG) ? cfg
                     : {stat_wr[7:2], wlatch, wbusy};
            end
        end
    end
    // The line toggles while it would float, so a stale bit never matches.
    always @(negedge sclk_i) begin
        if (!cs_n_i && nbit >= 8 && nbit < 16) begin
            miso_q = outb[15-nbit];
        end else begin
            miso_q = ~miso_q;
        end
    end
    always @(posedge cs_n_i) begin
        miso_q = ~miso_q;
        if (nbit > 0) begin
            ops.push_back(op);
            bits.push_back(nbit);
            if (op == frci_pkg::CMD_WRITE_ENABLE && nbit == 8) begin
                wlatch = 1'b1;
            end
            if (op == frci_pkg::CMD_REGISTER_WRITE) begin
                if (!wlatch) begin
                    wena_miss++;
                end
                stat_wr = sh[15:8];
                cfg = sh[7:0];
                wbusy = 1'b1;
                polls = POLLS;
            end
            if (op == frci_pkg::CMD_READ_STATUS && wbusy) begin
                polls--;
                wbusy = (polls > 0);
                wlatch = wbusy;
            end
        end
    end
endmodule : frci_flash_model
`default_nettype wire

/* frci_issuer.sv */
// Flash register command issuer: sequences register commands to a
// serial flash and hands each frame to the link engine across clocks.
// Assumes sys_clk_i and link_clk_i are unrelated; rst_i resets both.
// Function
// - Configuration read frame sends code 0x15 alone, then reads.
// - Write-enable frame always goes before any register write.
// - Write-enable frame is the lone byte 0x06.
// - Register write sends 0x01 then status byte then configuration byte.
// - Status bits 15..8 then configuration bits 7..0, MSB first.
// - Register write frame receives no bytes.
// - After register write, no other access until flash reports done.
// - Written values carry quad enable set and the dummy cycle field.
// - All frames are one-wire single rate; unused fill bytes are 0x00.
// - Completion polls status with 0x05 until write in progress clears.
`timescale 1ns/10ps
`default_nettype none
module frci_issuer (
    input  wire logic       sys_clk_i,
    input  wire logic       link_clk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic       op_i,
    input  wire logic [7:0] status_wr_i,
    input  wire logic [7:0] config_wr_i,
    input  wire logic [1:0] dummy_cycle_field_i,
    output logic            busy_o,
    output logic            done_o,
    output logic [7:0]      status_rd_o,
    output logic [7:0]      config_rd_o,
    output logic            write_enable_latch_o,
    output logic            flash_chip_select_n_o,
    output logic            flash_serial_clock_o,
    output logic            flash_serial_in_line_o,
    output logic            flash_serial_in_line_oe_o,
    input  wire logic       flash_serial_out_line_i
);
    frci_pkg::frci_seq_e state;
    frci_pkg::frci_seq_e next_state;
    logic [7:0]  frame_opcode;
    logic [1:0]  frame_ntx;
    logic        frame_nrx;
    logic [15:0] frame_data;
    logic        req_tgl;
    logic        ack_seen;
    logic        ack_sync;
    logic        ack_tgl;
    logic [7:0]  rx_byte;

    // ========================================================================
    // Decoding
    wire ack_evt = (ack_sync != ack_seen);
    wire issuing = (state == frci_pkg::S_RDCFG_ISSUE)
                || (state == frci_pkg::S_WENA_ISSUE)
                || (state == frci_pkg::S_REGW_ISSUE)
                || (state == frci_pkg::S_POLL_ISSUE);
    wire wbusy   = rx_byte[frci_pkg::WBUSY_BIT];

    // The value written forces quad enable and drops in the dummy field.
    wire [7:0] status_out = status_wr_i
                          | (8'h01 << frci_pkg::QUAD_BIT);
    wire [7:0] dummy_mask = 8'h03 << frci_pkg::DUMMY_LSB;
    wire [7:0] config_out = (config_wr_i & ~dummy_mask)
                          | (8'({dummy_cycle_field_i})
                             << frci_pkg::DUMMY_LSB);

    assign busy_o = (state != frci_pkg::S_IDLE);

    // ========================================================================
    // Sequencer next state
    always_comb begin
        next_state = state;
        unique case (state)
            frci_pkg::S_IDLE: begin
                if (start_i) begin
                    if (op_i == frci_pkg::OP_WRITE_REGS) begin
                        next_state = frci_pkg::S_WENA_ISSUE;
                    end else begin
                        next_state = frci_pkg::S_RDCFG_ISSUE;
                    end
                end
            end
            frci_pkg::S_RDCFG_ISSUE: next_state = frci_pkg::S_RDCFG_WAIT;
            frci_pkg::S_RDCFG_WAIT: begin
                if (ack_evt) begin
                    next_state = frci_pkg::S_IDLE;
                end
            end
            frci_pkg::S_WENA_ISSUE: next_state = frci_pkg::S_WENA_WAIT;
            frci_pkg::S_WENA_WAIT: begin
                if (ack_evt) begin
                    next_state = frci_pkg::S_REGW_ISSUE;
                end
            end
            frci_pkg::S_REGW_ISSUE: next_state = frci_pkg::S_REGW_WAIT;
            frci_pkg::S_REGW_WAIT: begin
                if (ack_evt) begin
                    next_state = frci_pkg::S_POLL_ISSUE;
                end
            end
            frci_pkg::S_POLL_ISSUE: next_state = frci_pkg::S_POLL_WAIT;
            frci_pkg::S_POLL_WAIT: begin
                if (ack_evt) begin
                    if (wbusy) begin
                        next_state = frci_pkg::S_POLL_ISSUE;
                    end else begin
                        next_state = frci_pkg::S_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= frci_pkg::S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ========================================================================
    // Frame set-up. The fields stay put until the link answers, so the
    // link may read them once it sees the request toggle.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_opcode <= frci_pkg::FILL_BYTE;
            frame_ntx    <= frci_pkg::TX_NONE;
            frame_nrx    <= frci_pkg::RX_NONE;
            frame_data   <= {frci_pkg::FILL_BYTE, frci_pkg::FILL_BYTE};
        end else begin
            unique case (state)
                frci_pkg::S_RDCFG_ISSUE: begin
                    frame_opcode <= frci_pkg::CMD_READ_CONFIG;
                    frame_ntx    <= frci_pkg::TX_NONE;
                    frame_nrx    <= frci_pkg::RX_ONE;
                    frame_data   <= {frci_pkg::FILL_BYTE,
                                     frci_pkg::FILL_BYTE};
                end
                frci_pkg::S_WENA_ISSUE: begin
                    frame_opcode <= frci_pkg::CMD_WRITE_ENABLE;
                    frame_ntx    <= frci_pkg::TX_NONE;
                    frame_nrx    <= frci_pkg::RX_NONE;
                    frame_data   <= {frci_pkg::FILL_BYTE,
                                     frci_pkg::FILL_BYTE};
                end
                frci_pkg::S_REGW_ISSUE: begin
                    frame_opcode <= frci_pkg::CMD_REGISTER_WRITE;
                    frame_ntx    <= frci_pkg::TX_TWO;
                    frame_nrx    <= frci_pkg::RX_NONE;
                    frame_data   <= {status_out, config_out};
                end
                frci_pkg::S_POLL_ISSUE: begin
                    frame_opcode <= frci_pkg::CMD_READ_STATUS;
                    frame_ntx    <= frci_pkg::TX_NONE;
                    frame_nrx    <= frci_pkg::RX_ONE;
                    frame_data   <= {frci_pkg::FILL_BYTE,
                                     frci_pkg::FILL_BYTE};
                end
                default: begin
                    frame_opcode <= frame_opcode;
                end
            endcase
        end
    end

    // ========================================================================
    // Request toggle, answer capture and results.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_tgl  <= 1'b0;
            ack_seen <= 1'b0;
        end else begin
            if (issuing) begin
                req_tgl <= ~req_tgl;
            end
            if (ack_evt) begin
                ack_seen <= ack_sync;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_o               <= 1'b0;
            status_rd_o          <= frci_pkg::REG_RESET;
            config_rd_o          <= frci_pkg::REG_RESET;
            write_enable_latch_o <= 1'b0;
        end else begin
            done_o <= busy_o && (next_state == frci_pkg::S_IDLE);
            if (ack_evt && state == frci_pkg::S_RDCFG_WAIT) begin
                config_rd_o <= rx_byte;
            end
            if (ack_evt && state == frci_pkg::S_POLL_WAIT) begin
                status_rd_o <= rx_byte;
            end
            // Mirrors the latch that the flash sets on write enable and
            // clears once the register write has completed.
            if (ack_evt && state == frci_pkg::S_WENA_WAIT) begin
                write_enable_latch_o <= 1'b1;
            end else if (ack_evt && state == frci_pkg::S_POLL_WAIT && !wbusy)
            begin
                write_enable_latch_o <= 1'b0;
            end
        end
    end

    frci_sync u_ack_sync (
        .clk_i (sys_clk_i),
        .rst_i (rst_i),
        .d_i   (ack_tgl),
        .q_o   (ack_sync)
    );

    frci_link u_link (
        .link_clk_i                (link_clk_i),
        .rst_i                     (rst_i),
        .req_tgl_i                 (req_tgl),
        .opcode_i                  (frame_opcode),
        .ntx_i                     (frame_ntx),
        .nrx_i                     (frame_nrx),
        .data_i                    (frame_data),
        .ack_tgl_o                 (ack_tgl),
        .rx_byte_o                 (rx_byte),
        .flash_chip_select_n_o     (flash_chip_select_n_o),
        .flash_serial_clock_o      (flash_serial_clock_o),
        .flash_serial_in_line_o    (flash_serial_in_line_o),
        .flash_serial_in_line_oe_o (flash_serial_in_line_oe_o),
        .flash_serial_out_line_i   (flash_serial_out_line_i)
    );

    // ========================================================================
    // Checks on the sequencer side.
    property p_rdcfg_frame;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state == frci_pkg::S_RDCFG_ISSUE) |=>
            (frame_opcode == 8'h15) && (frame_ntx == 2'h0) && frame_nrx;
    endproperty
    a_rdcfg_frame: assert property (p_rdcfg_frame)
        else $error("configuration read frame malformed");

    property p_wena_first;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state == frci_pkg::S_REGW_ISSUE) |->
            ($past(state) == frci_pkg::S_WENA_WAIT) && write_enable_latch_o;
    endproperty
    a_wena_first: assert property (p_wena_first)
        else $error("register write without write enable");

    property p_wena_frame;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state == frci_pkg::S_WENA_ISSUE) |=>
            (frame_opcode == 8'h06) && (frame_ntx == 2'h0) && !frame_nrx;
    endproperty
    a_wena_frame: assert property (p_wena_frame)
        else $error("write enable frame malformed");

    property p_regw_frame;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state == frci_pkg::S_REGW_ISSUE) |=>
            (frame_opcode == 8'h01) && (frame_ntx == 2'h2)
            && !frame_nrx && (frame_data == $past({status_out, config_out}));
    endproperty
    a_regw_frame: assert property (p_regw_frame)
        else $error("register write frame malformed");

    property p_regw_fields;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state == frci_pkg::S_REGW_WAIT) |->
            frame_data[8 + frci_pkg::QUAD_BIT]
            && (frame_data[frci_pkg::DUMMY_LSB +: 2]
                == $past(dummy_cycle_field_i));
    endproperty
    a_regw_fields: assert property (p_regw_fields)
        else $error("quad enable or dummy field not written");

    property p_wait_after_write;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state == frci_pkg::S_REGW_WAIT && ack_evt) |=>
            (state == frci_pkg::S_POLL_ISSUE) ##1
            (frame_opcode == 8'h05) && frame_nrx;
    endproperty
    a_wait_after_write: assert property (p_wait_after_write)
        else $error("no completion wait after register write");

    property p_poll_repeats;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state == frci_pkg::S_POLL_WAIT && ack_evt && wbusy) |=>
            (state == frci_pkg::S_POLL_ISSUE) && !done_o;
    endproperty
    a_poll_repeats: assert property (p_poll_repeats)
        else $error("polling stopped while write in progress");

    property p_done_after_idle;
        @(posedge sys_clk_i) disable iff (rst_i)
        (state == frci_pkg::S_POLL_WAIT && ack_evt && !wbusy) |=>
            done_o && (status_rd_o == $past(rx_byte)) && !busy_o;
    endproperty
    a_done_after_idle: assert property (p_done_after_idle)
        else $error("completion not reported after write finished");
endmodule : frci_issuer
`default_nettype wire

/* frci_issuer_tb.sv */
// Self-checking bench for the issuer against the flash model.
// Assumes a 40 MHz system clock and an unrelated 30 ns link clock.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, want) begin total_checks++; if ((got) !== (want)) begin \
    bad_count++; $display("Error %0t: got %h want %h", $time, got, want); \
    end end
module frci_issuer_tb;
    logic       sys_clk = 1'b0;
    logic       link_clk = 1'b0;
    logic       rst = 1'b1;
    logic       start = 1'b0;
    logic       op = 1'b0;
    logic [7:0] st_wr = 8'h00;
    logic [7:0] cf_wr = 8'h00;
    logic [1:0] dmy = 2'h0;
    logic       busy, done, wlatch, cs_n, sclk, mosi, mosi_oe, miso;
    logic [7:0] st_rd, cf_rd, s, c;
    int         bad_count = 0;
    int         total_checks = 0;

    initial forever #12.5 sys_clk = ~sys_clk;
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end

    frci_issuer i_dut (.sys_clk_i(sys_clk), .link_clk_i(link_clk),
        .rst_i(rst), .start_i(start), .op_i(op), .status_wr_i(st_wr),
        .config_wr_i(cf_wr), .dummy_cycle_field_i(dmy), .busy_o(busy),
        .done_o(done), .status_rd_o(st_rd), .config_rd_o(cf_rd),
        .write_enable_latch_o(wlatch), .flash_chip_select_n_o(cs_n),
        .flash_serial_clock_o(sclk), .flash_serial_in_line_o(mosi),
        .flash_serial_in_line_oe_o(mosi_oe), .flash_serial_out_line_i(miso));
    frci_flash_model i_flash (.cs_n_i(cs_n), .sclk_i(sclk), .mosi_i(mosi),
        .miso_o(miso));

    // ========================================================================
    // Tasks
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task automatic exp_frame(input logic [7:0] c, input int nb);
        logic [7:0] got_op;
        int         got_nb;
        got_op = i_flash.ops.pop_front();
        got_nb = i_flash.bits.pop_front();
        `CHK(got_op, c)
        `CHK(got_nb, nb)
    endtask : exp_frame

    // A poke holds start a second cycle with a read while busy.
    task automatic run_op(input logic o, input logic [7:0] sv,
                          input logic [7:0] cv, input logic [1:0] d,
                          input logic poke);
        int n;
        @(posedge sys_clk);
        start <= 1'b1;
        op    <= o;
        st_wr <= sv;
        cf_wr <= cv;
        dmy   <= d;
        @(posedge sys_clk);
        start <= poke;
        op    <= 1'b0;
        #1;
        `CHK(busy, 1'b1)
        @(posedge sys_clk);
        start <= 1'b0;
        #1;
        for (n = 0; n < 20000 && done !== 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        if (n == 20000) begin
            bad_count++;
            test_done();
        end else begin
            `CHK(busy, 1'b0)
        end
    endtask : run_op

    // ========================================================================
    // Sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        `CHK(cs_n, 1'b1)
        `CHK(mosi_oe, 1'b0)
        i_flash.cfg = 8'ha5;
        run_op(frci_pkg::OP_READ_CONFIG, 8'h00, 8'h00, 2'h0, 1'b0);
        `CHK(cf_rd, 8'ha5)
        exp_frame(frci_pkg::CMD_READ_CONFIG, 16);
        for (int i = 0; i < 4; i++) begin
            s = 8'h0c + 8'(i);
            c = 8'hd5 - 8'(i);
            run_op(frci_pkg::OP_WRITE_REGS, s, c, 2'(i), i == 1);
            exp_frame(frci_pkg::CMD_WRITE_ENABLE, 8);
            exp_frame(frci_pkg::CMD_REGISTER_WRITE, 24);
            for (int k = 0; k < 3; k++) begin
                exp_frame(frci_pkg::CMD_READ_STATUS, 16);
            end
            `CHK(i_flash.ops.size(), 0)
            `CHK(i_flash.wena_miss, 0)
            `CHK(i_flash.stat_wr, s | 8'h40)
            `CHK(i_flash.cfg, {2'(i), c[5:0]})
            `CHK(st_rd, 8'h4c)
            `CHK(wlatch, 1'b0)
            run_op(frci_pkg::OP_READ_CONFIG, 8'h00, 8'h00, 2'h0, 1'b0);
            `CHK(cf_rd, {2'(i), c[5:0]})
            exp_frame(frci_pkg::CMD_READ_CONFIG, 16);
        end
        test_done();
    end
endmodule : frci_issuer_tb
`default_nettype wire

/* frci_link.sv */
// Link engine: frames one command on the serial flash pins.
// Assumes link_clk_i is a free clock; the serial clock is half its rate.
// Frame fields are held stable by the issuer while a request is open.
`timescale 1ns/10ps
`default_nettype none
module frci_link (
    input  wire logic        link_clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_tgl_i,
    input  wire logic [7:0]  opcode_i,
    input  wire logic [1:0]  ntx_i,
    input  wire logic        nrx_i,
    input  wire logic [15:0] data_i,
    output logic             ack_tgl_o,
    output logic [7:0]       rx_byte_o,
    output logic             flash_chip_select_n_o,
    output logic             flash_serial_clock_o,
    output logic             flash_serial_in_line_o,
    output logic             flash_serial_in_line_oe_o,
    input  wire logic        flash_serial_out_line_i
);
    frci_pkg::frci_link_e state;
    logic        req_sync;
    logic        req_seen;
    logic [4:0]  cnt;
    logic [23:0] tx_shift;
    logic [7:0]  rx_shift;

    wire        req_evt  = (req_sync != req_seen);
    wire [1:0]  nbytes   = 2'(2'd1 + ntx_i + {1'b0, nrx_i});
    wire [4:0]  last_bit = {nbytes, 3'b000} - 5'd1;
    wire        rx_phase = nrx_i && (cnt[4:3] == 2'(2'd1 + ntx_i));
    wire        at_last  = (cnt == last_bit);

    frci_sync u_req_sync (
        .clk_i (link_clk_i),
        .rst_i (rst_i),
        .d_i   (req_tgl_i),
        .q_o   (req_sync)
    );

    // ========================================================================
    // Frame engine: bits leave while the clock is low and the flash output
    // is taken just before each falling edge of the receive byte.
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state                     <= frci_pkg::L_IDLE;
            req_seen                  <= 1'b0;
            ack_tgl_o                 <= 1'b0;
            rx_byte_o                 <= frci_pkg::REG_RESET;
            cnt                       <= 5'h00;
            tx_shift                  <= 24'h000000;
            rx_shift                  <= frci_pkg::REG_RESET;
            flash_chip_select_n_o     <= 1'b1;
            flash_serial_clock_o      <= 1'b0;
            flash_serial_in_line_o    <= 1'b0;
            flash_serial_in_line_oe_o <= 1'b0;
        end else begin
            unique case (state)
                frci_pkg::L_IDLE: begin
                    if (req_evt) begin
                        req_seen                  <= req_sync;
                        tx_shift  <= {opcode_i, data_i};
                        cnt                       <= 5'h00;
                        flash_chip_select_n_o     <= 1'b0;
                        flash_serial_in_line_oe_o <= 1'b1;
                        flash_serial_in_line_o    <= opcode_i[7];
                        state                     <= frci_pkg::L_SHIFT;
                    end
                end
                frci_pkg::L_SHIFT: begin
                    flash_serial_clock_o <= ~flash_serial_clock_o;
                    if (flash_serial_clock_o) begin
                        if (rx_phase) begin
                            rx_shift <= {rx_shift[6:0],
                                         flash_serial_out_line_i};
                        end
                        tx_shift               <= {tx_shift[22:0], 1'b0};
                        flash_serial_in_line_o <= tx_shift[22];
                        cnt                    <= cnt + 5'd1;
                        if (at_last) begin
                            state <= frci_pkg::L_END;
                        end
                    end
                end
                frci_pkg::L_END: begin
                    flash_chip_select_n_o     <= 1'b1;
                    flash_serial_in_line_oe_o <= 1'b0;
                    flash_serial_in_line_o    <= 1'b0;
                    rx_byte_o                 <= rx_shift;
                    ack_tgl_o                 <= ~ack_tgl_o;
                    state                     <= frci_pkg::L_IDLE;
                end
            endcase
        end
    end

    // ========================================================================
    // Checks on the link side.
    property p_cs_in_frame;
        @(posedge link_clk_i) disable iff (rst_i)
        (state == frci_pkg::L_SHIFT) |-> !flash_chip_select_n_o;
    endproperty
    a_cs_in_frame: assert property (p_cs_in_frame)
        else $error("chip select high inside a frame");

    property p_cs_rises_after_last;
        @(posedge link_clk_i) disable iff (rst_i)
        (state == frci_pkg::L_SHIFT && flash_serial_clock_o && at_last)
        |=> !flash_chip_select_n_o ##1 flash_chip_select_n_o;
    endproperty
    a_cs_rises_after_last: assert property (p_cs_rises_after_last)
        else $error("chip select not released after last bit");

    property p_clock_idle_low;
        @(posedge link_clk_i) disable iff (rst_i)
        flash_chip_select_n_o |-> !flash_serial_clock_o;
    endproperty
    a_clock_idle_low: assert property (p_clock_idle_low)
        else $error("serial clock runs outside a frame");
endmodule : frci_link
`default_nettype wire

/* frci_pkg.sv */
// Constants shared by the flash register command issuer and its link engine.
// Assumes a one-wire, mode-0 serial flash on the far side of the link.
package frci_pkg;

    // ========================================================================
    // Command codes
    localparam logic [7:0] CMD_READ_CONFIG   = 8'h15;
    localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] CMD_REGISTER_WRITE = 8'h01;
    localparam logic [7:0] CMD_READ_STATUS   = 8'h05;

    // ========================================================================
    // Frame shape
    localparam logic [1:0] TX_NONE  = 2'h0;
    localparam logic [1:0] TX_TWO   = 2'h2;
    localparam logic       RX_NONE  = 1'b0;
    localparam logic       RX_ONE   = 1'b1;
    localparam logic [7:0] FILL_BYTE = 8'h00;

    // ========================================================================
    // Flash register fields
    localparam int unsigned WBUSY_BIT = 0;
    localparam int unsigned QUAD_BIT  = 6;
    localparam int unsigned DUMMY_LSB = 6;

    // ========================================================================
    // Host operations and reset values
    localparam logic       OP_READ_CONFIG = 1'b0;
    localparam logic       OP_WRITE_REGS  = 1'b1;
    localparam logic [7:0] REG_RESET      = 8'h00;

    typedef enum logic [3:0] {
        S_IDLE, S_RDCFG_ISSUE, S_RDCFG_WAIT, S_WENA_ISSUE, S_WENA_WAIT,
        S_REGW_ISSUE, S_REGW_WAIT, S_POLL_ISSUE, S_POLL_WAIT
    } frci_seq_e;

    typedef enum logic [1:0] {L_IDLE, L_SHIFT, L_END} frci_link_e;

endpackage : frci_pkg

/* frci_sync.sv */
// Three-stage synchroniser for one level, with agreement filter.
// Assumes the input is a level that changes slowly against the clock.
`timescale 1ns/10ps
`default_nettype none
module frci_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic s1;
    logic s2;
    logic s3;

    // ========================================================================
    // Only the second stage reads the first; a change counts once stages
    // two and three agree.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1  <= 1'b0;
            s2  <= 1'b0;
            s3  <= 1'b0;
            q_o <= 1'b0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                q_o <= s3;
            end
        end
    end
endmodule : frci_sync
`default_nettype wire
